// file: rtl/mrx_pkg.sv
// Package with opcode, widths and timing constants for the execution block.
package mrx_pkg;
	localparam int DATA_W    = 8;
	localparam int ADDR_W    = 7;
	localparam int PC_W      = 11;
	localparam int STK_DEPTH = 8;
	localparam int SP_W      = 4;
	localparam int REG_COUNT = 128;
	localparam int MSB_BIT   = 7;

	localparam logic [PC_W-1:0] PC_RESET = 11'h000;
	localparam logic [PC_W-1:0] PC_STEP  = 11'h001;
	localparam logic [SP_W-1:0] SP_RESET = 4'h0;
	localparam logic [SP_W-1:0] SP_STEP  = 4'h1;
	localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
	localparam logic [1:0] RET_CYCLES = 2'h2;

	typedef enum logic [2:0] {
		OP_NOP,
		OP_LOAD_IMM,
		OP_MOVE_REG,
		OP_RET_INT,
		OP_RET_IMM,
		OP_ROTATE_LEFT
	} mrx_op_t;

	typedef struct packed {
		mrx_op_t             op;
		logic [ADDR_W-1:0]   reg_addr;
		logic                dest_reg;
		logic [DATA_W-1:0]   imm;
	} mrx_instr_t;

	typedef struct packed {
		logic carry;
		logic zero;
		logic global_interrupt_enable;
	} mrx_flags_t;
endpackage

// file: rtl/mrx_exec.sv
// Execution core for load, move, return and rotate-left instructions.
`timescale 1ns/1ns

// Summary of operation
// RULE_01: Load immediate puts 8-bit operand into accumulator in one cycle, no flags.
// RULE_02: Move copies register to accumulator if dest bit 0, else back to itself.
// RULE_03: Move sets zero flag when moved value is zero, else clears it.
// RULE_04: Return from interrupt loads PC from stack top, sets interrupt enable, two cycles.
// RULE_05: Return with value loads immediate into accumulator, PC from stack, two cycles.
// RULE_06: Every return pops the stack after taking the PC from the old top.
// RULE_07: Rotate left through carry: carry to bit 0, bits shift up, bit 7 to carry.
// RULE_08: Rotate result goes to accumulator or register by dest bit; carry only; one cycle.
// RULE_09: No-operation changes nothing but advances PC by one in one cycle.
module mrx_exec (
	input  wire logic                        clock_i,
	input  wire logic                        rst_n_i,
	input  wire logic                        instr_valid_i,
	input  wire mrx_pkg::mrx_instr_t         instr_i,
	input  wire logic                        push_i,
	input  wire logic [mrx_pkg::PC_W-1:0]    push_addr_i,
	output logic                             instr_ready_o,
	output logic [mrx_pkg::DATA_W-1:0]       accumulator_o,
	output mrx_pkg::mrx_flags_t              flags_o,
	output logic [mrx_pkg::PC_W-1:0]         pc_o,
	output logic [mrx_pkg::SP_W-1:0]         stack_level_o
);

	// ****************************************
	// State
	// ****************************************
	typedef enum logic [0:0] {
		ST_IDLE,
		ST_RET_WAIT
	} mrx_state_t;

	mrx_state_t                      state_r;
	mrx_state_t                      state_nxt;
	logic [mrx_pkg::DATA_W-1:0]      acc_r;
	logic [mrx_pkg::DATA_W-1:0]      acc_nxt;
	mrx_pkg::mrx_flags_t             flags_r;
	mrx_pkg::mrx_flags_t             flags_nxt;
	logic [mrx_pkg::PC_W-1:0]        pc_r;
	logic [mrx_pkg::PC_W-1:0]        pc_nxt;
	logic [mrx_pkg::SP_W-1:0]        sp_r;
	logic [mrx_pkg::SP_W-1:0]        sp_nxt;
	logic [mrx_pkg::DATA_W-1:0]      regs_r [mrx_pkg::REG_COUNT];
	logic [mrx_pkg::PC_W-1:0]        stack_r [mrx_pkg::STK_DEPTH];

	// ****************************************
	// Decode
	// ****************************************
	localparam int LOC_ADDR_W = mrx_pkg::ADDR_W;
	localparam int STK_IDX_W  = $clog2(mrx_pkg::STK_DEPTH);

	wire logic                       take     = instr_valid_i && (state_r == ST_IDLE);
	wire logic [mrx_pkg::DATA_W-1:0] src_val  = regs_r[instr_i.reg_addr];
	wire logic [mrx_pkg::DATA_W-1:0] rot_val  = {src_val[mrx_pkg::MSB_BIT-1:0], flags_r.carry}; // [RULE_07]
	wire logic                       rot_cy   = src_val[mrx_pkg::MSB_BIT]; // [RULE_07]
	wire logic                       is_ret   = (instr_i.op == mrx_pkg::OP_RET_INT) ||
	                                            (instr_i.op == mrx_pkg::OP_RET_IMM);
	wire logic                       wr_move  = take && instr_i.dest_reg &&
	                                            (instr_i.op == mrx_pkg::OP_MOVE_REG); // [RULE_02]
	wire logic                       wr_rot   = take && instr_i.dest_reg &&
	                                            (instr_i.op == mrx_pkg::OP_ROTATE_LEFT); // [RULE_08]
	wire logic                       do_push  = push_i && (state_r == ST_IDLE) && !take;
	wire logic [mrx_pkg::SP_W-1:0]   top_idx  = sp_r - mrx_pkg::SP_STEP;

	// Returns take a second cycle; the single-cycle ones complete on acceptance.
	assign instr_ready_o = (state_r == ST_IDLE);

	always_comb begin
		state_nxt = state_r;
		acc_nxt   = acc_r;
		flags_nxt = flags_r;
		pc_nxt    = pc_r;
		sp_nxt    = sp_r;
		if (state_r == ST_RET_WAIT) begin
			state_nxt = ST_IDLE;
		end else if (take) begin
			pc_nxt = pc_r + mrx_pkg::PC_STEP; // [RULE_09]
			case (instr_i.op)
				mrx_pkg::OP_NOP: begin
					pc_nxt = pc_r + mrx_pkg::PC_STEP; // [RULE_09]
				end
				mrx_pkg::OP_LOAD_IMM: begin
					acc_nxt = instr_i.imm; // [RULE_01]
				end
				mrx_pkg::OP_MOVE_REG: begin
					if (!instr_i.dest_reg) begin
						acc_nxt = src_val; // [RULE_02]
					end
					flags_nxt.zero = (src_val == mrx_pkg::DATA_ZERO); // [RULE_03]
				end
				mrx_pkg::OP_ROTATE_LEFT: begin
					if (!instr_i.dest_reg) begin
						acc_nxt = rot_val; // [RULE_08]
					end
					flags_nxt.carry = rot_cy; // [RULE_07]
				end
				mrx_pkg::OP_RET_INT, mrx_pkg::OP_RET_IMM: begin
					pc_nxt    = stack_r[top_idx[$clog2(mrx_pkg::STK_DEPTH)-1:0]]; // [RULE_06]
					sp_nxt    = sp_r - mrx_pkg::SP_STEP; // [RULE_06]
					state_nxt = ST_RET_WAIT; // [RULE_04] [RULE_05]
					if (instr_i.op == mrx_pkg::OP_RET_INT) begin
						flags_nxt.global_interrupt_enable = 1'b1; // [RULE_04]
					end else begin
						acc_nxt = instr_i.imm; // [RULE_05]
					end
				end
				default: begin
					pc_nxt = pc_r;
				end
			endcase
		end else if (do_push) begin
			sp_nxt = sp_r + mrx_pkg::SP_STEP;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc_r <= mrx_pkg::DATA_ZERO;
		end else begin
			acc_r <= acc_nxt;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flags_r <= '0;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pc_r <= mrx_pkg::PC_RESET;
		end else begin
			pc_r <= pc_nxt;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sp_r <= mrx_pkg::SP_RESET;
		end else begin
			sp_r <= sp_nxt;
		end
	end

	// ****************************************
	// Register file
	// ****************************************
	// Every entry clears on reset, so a move or rotate never reads an unknown value.
	wire logic                       reg_we   = wr_move || wr_rot;
	wire logic [mrx_pkg::DATA_W-1:0] reg_wdat = wr_rot ? rot_val : src_val; // [RULE_02] [RULE_08]

	generate
		for (genvar gi = 0; gi < mrx_pkg::REG_COUNT; gi++) begin : g_reg
			wire logic hit = reg_we && (instr_i.reg_addr == LOC_ADDR_W'(gi));
			always_ff @(posedge clock_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					regs_r[gi] <= mrx_pkg::DATA_ZERO;
				end else if (hit) begin
					regs_r[gi] <= reg_wdat;
				end
			end
		end
	endgenerate

	// ****************************************
	// Return stack
	// ****************************************
	// The stack holds addresses only and needs no reset; a ninth push wraps over the oldest entry.
	generate
		for (genvar gs = 0; gs < mrx_pkg::STK_DEPTH; gs++) begin : g_stk
			wire logic load = do_push && (sp_r[STK_IDX_W-1:0] == STK_IDX_W'(gs));
			always_ff @(posedge clock_i) begin
				if (load) begin
					stack_r[gs] <= push_addr_i;
				end
			end
		end
	endgenerate

	// ****************************************
	// Outputs
	// ****************************************
	assign accumulator_o = acc_r;
	assign flags_o       = flags_r;
	assign pc_o          = pc_r;
	assign stack_level_o = sp_r;
endmodule

// file: dv/mrx_exec_checker.sv
// Port checker of the execution core.
`timescale 1ns/1ns
module mrx_exec_checker (
	input wire logic                clock_i,
	input wire logic                rst_n_i,
	input wire logic                instr_valid_i,
	input wire mrx_pkg::mrx_instr_t instr_i,
	input wire logic                push_i,
	input wire logic [10:0]         push_addr_i,
	input wire logic                instr_ready_o,
	input wire logic [7:0]          accumulator_o,
	input wire mrx_pkg::mrx_flags_t flags_o,
	input wire logic [10:0]         pc_o,
	input wire logic [3:0]          stack_level_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	wire tk = instr_valid_i && instr_ready_o;
	wire ld = tk && instr_i.op == mrx_pkg::OP_LOAD_IMM;
	wire np = tk && instr_i.op == mrx_pkg::OP_NOP;
	wire mv = tk && instr_i.op == mrx_pkg::OP_MOVE_REG;
	wire ri = tk && instr_i.op == mrx_pkg::OP_RET_INT;
	wire rv = tk && instr_i.op == mrx_pkg::OP_RET_IMM;
	wire ro = tk && instr_i.op == mrx_pkg::OP_ROTATE_LEFT;
	AST_LOAD: assert property (ld |=> accumulator_o == $past(instr_i.imm)
		&& $stable(flags_o)) else $error("load result wrong");
	AST_NOP: assert property (np |=> $stable(accumulator_o) && $stable(flags_o)
		&& pc_o == $past(pc_o) + 11'h001) else $error("no-op changed state");
	AST_RETI: assert property (ri |=> flags_o.global_interrupt_enable && !instr_ready_o ##1 instr_ready_o)
		else $error("interrupt return wrong");
	AST_RETV: assert property (rv |=> accumulator_o == $past(instr_i.imm)
		&& $stable(flags_o) && !instr_ready_o) else $error("value return wrong");
	AST_POP: assert property (ri || rv |=> stack_level_o == $past(stack_level_o) - 4'h1)
		else $error("stack not popped");
	AST_ROT: assert property (ro && !instr_i.dest_reg |=> accumulator_o[0] == $past(flags_o.carry))
		else $error("carry not rotated in");
	AST_ROTD: assert property (ro && instr_i.dest_reg |=> $stable(accumulator_o)
		&& $stable(flags_o.zero)) else $error("rotate touched accumulator");
	AST_MOVE: assert property (mv && instr_i.dest_reg |=> $stable(accumulator_o)
		&& $stable(flags_o.carry)) else $error("move touched accumulator");
endmodule
bind mrx_exec mrx_exec_checker i_mrx_exec_checker (.*);

// file: dv/mrx_exec_tb.sv
// Self-checking testbench of the execution core.
`timescale 1ns/1ns
module mrx_exec_tb;
	logic                clock_i, rst_n_i, instr_valid_i, push_i, instr_ready_o;
	mrx_pkg::mrx_instr_t instr_i;
	mrx_pkg::mrx_flags_t flags_o;
	logic [10:0]         push_addr_i, pc_o;
	logic [7:0]          accumulator_o;
	logic [3:0]          stack_level_o;
	int                  n_fail = 0;
	int                  check_count = 0;
	mrx_exec i_mrx_exec (.*);
	initial begin
		clock_i = 1'b0;
		forever #20 clock_i = ~clock_i;
	end
	task automatic chk(string what, logic [10:0] exp, logic [10:0] got);
		check_count++;
		if (got !== exp) begin
			$display("unexpected %s: expected %h seen %h", what, exp, got);
			n_fail++;
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Valid is held until the core is ready, so a return's busy cycle is never lost.
	task automatic issue(mrx_pkg::mrx_op_t op, logic d, logic [7:0] imm);
		int n;
		@(posedge clock_i);
		instr_valid_i <= 1'b1;
		instr_i <= '{op, 7'h05, d, imm};
		for (n = 0; n < 8; n++) begin
			#1;
			if (instr_ready_o === 1'b1) break;
			@(posedge clock_i);
		end
		if (n == 8) begin
			n_fail++;
		end
		@(posedge clock_i);
		instr_valid_i <= 1'b0;
		#1;
	endtask
	task automatic push(logic [10:0] a);
		@(posedge clock_i);
		push_i <= 1'b1;
		push_addr_i <= a;
		@(posedge clock_i);
		push_i <= 1'b0;
	endtask
	task automatic t_load_nop();
		issue(mrx_pkg::OP_LOAD_IMM, 1'b0, 8'hA5);
		chk("acc", 11'h0A5, {3'h0, accumulator_o});
		issue(mrx_pkg::OP_NOP, 1'b0, 8'h00);
		chk("pc", 11'h002, pc_o);
		$display("load and no-op test done");
	endtask
	task automatic t_ret();
		push(11'h123);
		push(11'h2AB);
		issue(mrx_pkg::OP_RET_IMM, 1'b0, 8'h3C);
		chk("acc", 11'h03C, {3'h0, accumulator_o});
		chk("pc", 11'h2AB, pc_o);
		chk("level", 11'h001, {7'h00, stack_level_o});
		issue(mrx_pkg::OP_RET_INT, 1'b0, 8'h00);
		chk("pc", 11'h123, pc_o);
		chk("gie", 11'h001, {10'h000, flags_o.global_interrupt_enable});
		chk("level", 11'h000, {7'h00, stack_level_o});
		$display("return test done");
	endtask
	task automatic t_rot_move();
		issue(mrx_pkg::OP_ROTATE_LEFT, 1'b0, 8'h00);
		chk("acc0", 11'h000, {10'h000, accumulator_o[0]});
		chk("carry", 11'h000, {10'h000, flags_o.carry});
		issue(mrx_pkg::OP_ROTATE_LEFT, 1'b1, 8'h00);
		chk("acc", 11'h000, {3'h0, accumulator_o});
		issue(mrx_pkg::OP_MOVE_REG, 1'b1, 8'h00);
		chk("zero", 11'h001, {10'h000, flags_o.zero});
		chk("pc", 11'h126, pc_o);
		issue(mrx_pkg::OP_LOAD_IMM, 1'b0, 8'h5A);
		issue(mrx_pkg::OP_MOVE_REG, 1'b0, 8'h00);
		chk("acc", 11'h000, {3'h0, accumulator_o});
		$display("rotate and move test done");
	endtask
	initial begin
		rst_n_i = 1'b0;
		instr_valid_i = 1'b0;
		push_i = 1'b0;
		push_addr_i = 11'h000;
		instr_i = '0;
		repeat (16) @(posedge clock_i);
		rst_n_i <= 1'b1;
		t_load_nop();
		t_ret();
		t_rot_move();
		results();
	end
	initial begin
		repeat (2000) @(posedge clock_i);
		n_fail++;
		results();
	end
endmodule
